// file: inc/art_pkg.sv
// Purpose: constants for the auto-reload timer with split mode
// Assumes: 8-bit special function register port, single clock
// Notes: offsets of registers without a printed address are local picks
package art_pkg;
    localparam logic [7:0] ART_CTRL_ADDR = 8'h91;
    localparam logic [7:0] ART_RLD_LO_ADDR = 8'h92;
    localparam logic [7:0] ART_RLD_HI_ADDR = 8'h93;
    localparam logic [7:0] ART_CNT_LO_ADDR = 8'h94;
    localparam logic [7:0] ART_CNT_HI_ADDR = 8'h95;
    localparam logic [7:0] ART_CLKCTL_ADDR = 8'h96;
    localparam logic [7:0] ART_IRQ_STAT_ADDR = 8'h97;
    localparam logic [7:0] ART_IRQ_MASK_ADDR = 8'h98;
    localparam logic [7:0] ART_CTRL_RST = 8'h00;
    localparam logic [7:0] ART_BYTE_RST = 8'h00;
    localparam logic [7:0] ART_CTRL_WMASK = 8'hed;
    localparam int ART_HOF_BIT = 7;
    localparam int ART_LOF_BIT = 6;
    localparam int ART_LIE_BIT = 5;
    localparam int ART_SPLIT_BIT = 3;
    localparam int ART_RUN_BIT = 2;
    localparam int ART_XSEL_BIT = 0;
    localparam int ART_HFAST_BIT = 1;
    localparam int ART_LFAST_BIT = 0;
    localparam int ART_SYS_DIV = 12;
    localparam int ART_EXT_DIV = 8;
    localparam logic [3:0] ART_SYS_DIV_LAST = 4'hb;
    localparam logic [2:0] ART_EXT_DIV_LAST = 3'h7;
endpackage : art_pkg

// file: core/art_clk_sel.sv
// Purpose: count enable for one timer byte from a three-way source choice
// Assumes: ticks are one-cycle pulses on the system clock
// Notes: pure selection, no state
`timescale 1ns/1ns
module art_clk_sel
    import art_pkg::*;
(
    input wire logic fast_sel_in,
    input wire logic ext_sel_in,
    input wire logic div12_tick_in,
    input wire logic ext8_tick_in,
    output logic tick_out
);
    assign tick_out = fast_sel_in ? 1'b1 : (ext_sel_in ? ext8_tick_in : div12_tick_in);
endmodule : art_clk_sel

// file: core/art_timer.sv
// Purpose: auto-reload timer, one 16-bit counter or two 8-bit counters
// Assumes: external oscillator no faster than half of mclk_in, raw on ext_osc_in
// Notes: registers on an 8-bit strobe port, read data one cycle later
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ns
// Summary of operation
// - split select zero gives one 16-bit counter, one gives two 8-bit ones
// - 16-bit rollover from ffff loads both reload bytes, sets high flag
// - 16-bit mode requests interrupt on every full overflow when enabled
// - 16-bit mode with low enable also requests on low byte rollover
// - split mode reloads each byte from its own reload register
// - run bit gates whole counter, or only high byte in split mode
// - high byte counts on system clock, clock over 12, or external over 8
// - low byte uses the same choice with its own fast select bit
// - external clock over 8 is synchronised before use as count enable
// - split mode sets high or low flag when that byte rolls over
// - split mode requests on high overflow, either with low enable
// - overflow flags stay set until software writes them zero
module art_timer
    import art_pkg::*;
(
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic ext_osc_in,
    input wire logic global_irq_en_in,
    output logic [7:0] rdata_out,
    output logic timer_irq_out,
    output logic event_irq_out
);
    logic [7:0] ctrl_r;
    logic [7:0] ctrl_nxt;
    logic [7:0] rld_lo_r;
    logic [7:0] rld_hi_r;
    logic [7:0] cnt_lo_r;
    logic [7:0] cnt_lo_nxt;
    logic [7:0] cnt_hi_r;
    logic [7:0] cnt_hi_nxt;
    logic [1:0] clkctl_r;
    logic [1:0] stat_r;
    logic [1:0] stat_nxt;
    logic [1:0] mask_r;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic [3:0] div12_r;
    logic [2:0] ext_div_r;
    logic ext_div_msb_d_r;
    logic osc_meta_r;
    logic osc_sync_r;
    logic osc_prev_r;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
        hit = (a == ref_a);
    endfunction : hit

    function automatic logic is_top(input logic [7:0] v);
        is_top = (v == 8'hff);
    endfunction : is_top

    wire wr_ctrl = wr_in && hit(addr_in, ART_CTRL_ADDR);
    wire wr_rlo = wr_in && hit(addr_in, ART_RLD_LO_ADDR);
    wire wr_rhi = wr_in && hit(addr_in, ART_RLD_HI_ADDR);
    wire wr_clo = wr_in && hit(addr_in, ART_CNT_LO_ADDR);
    wire wr_chi = wr_in && hit(addr_in, ART_CNT_HI_ADDR);
    wire wr_cck = wr_in && hit(addr_in, ART_CLKCTL_ADDR);
    wire wr_msk = wr_in && hit(addr_in, ART_IRQ_MASK_ADDR);
    wire rd_stat = rd_in && hit(addr_in, ART_IRQ_STAT_ADDR);

    wire split = ctrl_r[ART_SPLIT_BIT];
    wire run = ctrl_r[ART_RUN_BIT];
    wire xsel = ctrl_r[ART_XSEL_BIT];
    wire low_ie = ctrl_r[ART_LIE_BIT];

    // prescalers run free so a source switch never restarts a partial count
    wire div12_tick = (div12_r == ART_SYS_DIV_LAST);
    // oscillator edges sampled only after two flops; limit: osc <= half the system clock
    wire osc_rise = osc_sync_r && !osc_prev_r;
    wire ext8_tick = ext_div_r[2] && !ext_div_msb_d_r;
    logic tick_hi;
    logic tick_lo;

    art_clk_sel u_sel_hi (
        .fast_sel_in(clkctl_r[ART_HFAST_BIT]),
        .ext_sel_in(xsel),
        .div12_tick_in(div12_tick),
        .ext8_tick_in(ext8_tick),
        .tick_out(tick_hi)
    );

    art_clk_sel u_sel_lo (
        .fast_sel_in(clkctl_r[ART_LFAST_BIT]),
        .ext_sel_in(xsel),
        .div12_tick_in(div12_tick),
        .ext8_tick_in(ext8_tick),
        .tick_out(tick_lo)
    );

    // 16-bit mode counts on the low byte source
    wire en16 = !split && run && tick_lo;
    wire en_lo = split ? tick_lo : en16;
    wire en_hi = split ? (run && tick_hi) : en16;
    wire lo_top = is_top(cnt_lo_r);
    wire hi_top = is_top(cnt_hi_r);
    wire lo_ovf = en_lo && lo_top;
    wire full16 = en16 && lo_top && hi_top;
    wire hi_ovf = split ? (en_hi && hi_top) : full16;

    always_comb
    begin
        cnt_lo_nxt = cnt_lo_r;
        cnt_hi_nxt = cnt_hi_r;
        if (split)
        begin
            if (en_lo)
                cnt_lo_nxt = lo_top ? rld_lo_r : cnt_lo_r + 8'h01;
            if (en_hi)
                cnt_hi_nxt = hi_top ? rld_hi_r : cnt_hi_r + 8'h01;
        end
        else if (en16)
        begin
            if (full16)
            begin
                cnt_lo_nxt = rld_lo_r;
                cnt_hi_nxt = rld_hi_r;
            end
            else
            begin
                cnt_lo_nxt = cnt_lo_r + 8'h01;
                if (lo_top)
                    cnt_hi_nxt = cnt_hi_r + 8'h01;
            end
        end
        // software write to a count byte takes priority over counting
        if (wr_clo)
            cnt_lo_nxt = wdata_in;
        if (wr_chi)
            cnt_hi_nxt = wdata_in;
    end

    always_comb
    begin
        ctrl_nxt = ctrl_r;
        if (wr_ctrl)
            ctrl_nxt = wdata_in & ART_CTRL_WMASK;
        // hardware set wins over a software clear in the same cycle
        if (hi_ovf)
            ctrl_nxt[ART_HOF_BIT] = 1'b1;
        if (lo_ovf)
            ctrl_nxt[ART_LOF_BIT] = 1'b1;
    end

    // sticky event status, cleared by reading it; set wins over the read
    always_comb
    begin
        stat_nxt = rd_stat ? 2'b00 : stat_r;
        if (hi_ovf)
            stat_nxt[1] = 1'b1;
        if (lo_ovf)
            stat_nxt[0] = 1'b1;
    end

    wire [7:0] unmapped = 8'h00;
    always_comb
    begin
        rdata_nxt = unmapped;
        case (addr_in)
            ART_CTRL_ADDR: rdata_nxt = ctrl_r;
            ART_RLD_LO_ADDR: rdata_nxt = rld_lo_r;
            ART_RLD_HI_ADDR: rdata_nxt = rld_hi_r;
            ART_CNT_LO_ADDR: rdata_nxt = cnt_lo_r;
            ART_CNT_HI_ADDR: rdata_nxt = cnt_hi_r;
            ART_CLKCTL_ADDR: rdata_nxt = {6'h00, clkctl_r};
            ART_IRQ_STAT_ADDR: rdata_nxt = {6'h00, stat_r};
            ART_IRQ_MASK_ADDR: rdata_nxt = {6'h00, mask_r};
            default: rdata_nxt = unmapped;
        endcase
    end

    // low flag raises a request only with low enable, in either mode
    wire flag_sel = ctrl_r[ART_HOF_BIT] || (low_ie && ctrl_r[ART_LOF_BIT]);
    assign timer_irq_out = global_irq_en_in && flag_sel;
    assign event_irq_out = |(stat_r & mask_r);
    assign rdata_out = rdata_r;

    // plain load and count registers, one short process each
    wire [7:0] rld_lo_nxt = wr_rlo ? wdata_in : rld_lo_r;
    wire [7:0] rld_hi_nxt = wr_rhi ? wdata_in : rld_hi_r;
    wire [1:0] clkctl_nxt = wr_cck ? wdata_in[1:0] : clkctl_r;
    wire [1:0] mask_nxt = wr_msk ? wdata_in[1:0] : mask_r;
    wire [3:0] div12_nxt = div12_tick ? 4'h0 : div12_r + 4'h1;
    wire [2:0] ext_div_nxt = osc_rise ? ext_div_r + 3'h1 : ext_div_r;

    always_ff @(posedge mclk_in)
    begin
        if (sys_rst_in)
        begin
            ctrl_r <= ART_CTRL_RST;
        end
        else
        begin
            ctrl_r <= ctrl_nxt;
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (sys_rst_in)
        begin
            rld_lo_r <= ART_BYTE_RST;
        end
        else
        begin
            rld_lo_r <= rld_lo_nxt;
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (sys_rst_in)
        begin
            rld_hi_r <= ART_BYTE_RST;
        end
        else
        begin
            rld_hi_r <= rld_hi_nxt;
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (sys_rst_in)
        begin
            cnt_lo_r <= ART_BYTE_RST;
        end
        else
        begin
            cnt_lo_r <= cnt_lo_nxt;
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (sys_rst_in)
        begin
            cnt_hi_r <= ART_BYTE_RST;
        end
        else
        begin
            cnt_hi_r <= cnt_hi_nxt;
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (sys_rst_in)
        begin
            clkctl_r <= 2'b00;
        end
        else
        begin
            clkctl_r <= clkctl_nxt;
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (sys_rst_in)
        begin
            stat_r <= 2'b00;
        end
        else
        begin
            stat_r <= stat_nxt;
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (sys_rst_in)
        begin
            mask_r <= 2'b00;
        end
        else
        begin
            mask_r <= mask_nxt;
        end
    end

    // read data stands for one cycle only, zero otherwise
    always_ff @(posedge mclk_in)
    begin
        if (sys_rst_in)
        begin
            rdata_r <= ART_BYTE_RST;
        end
        else
        begin
            rdata_r <= rd_in ? rdata_nxt : 8'h00;
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (sys_rst_in)
        begin
            div12_r <= 4'h0;
        end
        else
        begin
            div12_r <= div12_nxt;
        end
    end

    // only the second flop reads the first, so a metastable level never fans out
    always_ff @(posedge mclk_in)
    begin
        if (sys_rst_in)
        begin
            osc_meta_r <= 1'b0;
            osc_sync_r <= 1'b0;
            osc_prev_r <= 1'b0;
        end
        else
        begin
            osc_meta_r <= ext_osc_in;
            osc_sync_r <= osc_meta_r;
            osc_prev_r <= osc_sync_r;
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (sys_rst_in)
        begin
            ext_div_r <= 3'h0;
        end
        else
        begin
            ext_div_r <= ext_div_nxt;
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (sys_rst_in)
        begin
            ext_div_msb_d_r <= 1'b0;
        end
        else
        begin
            ext_div_msb_d_r <= ext_div_r[2];
        end
    end
endmodule : art_timer

// file: testbench/art_props.sv
// Purpose: port checker for the auto-reload timer
// Assumes: one clock, synchronous reset
// Notes: flags move on their own, so only software bits are compared
`timescale 1ns/1ns
module art_props
    import art_pkg::*;
(
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic ext_osc_in,
    input wire logic global_irq_en_in,
    input wire logic [7:0] rdata_out,
    input wire logic timer_irq_out,
    input wire logic event_irq_out
);
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (sys_rst_in);
    sequence rd_at(a);
        rd_in && addr_in == a;
    endsequence
    sequence wr_rd(a);
        wr_in && addr_in == a ##1 rd_at(a);
    endsequence
    chk_irq_gate: assert property (!global_irq_en_in |-> !timer_irq_out)
        else $error("request without enable");
    chk_irq_hold: assert property (
        timer_irq_out && !wr_in |=> timer_irq_out || !global_irq_en_in)
        else $error("request dropped without write");
    chk_rd_idle: assert property (!rd_in |=> rdata_out == 8'h00)
        else $error("read data outside read slot");
    chk_unmapped_rd: assert property (rd_at(8'h00) |=> rdata_out == 8'h00)
        else $error("unmapped read not zero");
    chk_ctrl_spare: assert property (rd_at(ART_CTRL_ADDR) |=> !rdata_out[4] && !rdata_out[1])
        else $error("spare control bits set");
    chk_ctrl_mode: assert property (wr_rd(ART_CTRL_ADDR) |=>
        (rdata_out & 8'h2d) == ($past(wdata_in, 2) & 8'h2d))
        else $error("control bits lost");
    chk_reload_lo: assert property (
        wr_rd(ART_RLD_LO_ADDR) |=> rdata_out == $past(wdata_in, 2))
        else $error("low reload lost");
    chk_reload_hi: assert property (
        wr_rd(ART_RLD_HI_ADDR) |=> rdata_out == $past(wdata_in, 2))
        else $error("high reload lost");
endmodule : art_props
bind art_timer art_props u_props (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .ext_osc_in(ext_osc_in), .global_irq_en_in(global_irq_en_in), .rdata_out(rdata_out),
    .timer_irq_out(timer_irq_out), .event_irq_out(event_irq_out));

// file: testbench/tb_top.sv
// Purpose: self-checking bench for the auto-reload timer
// Assumes: count clock picked per test in the clock control register and the control external select bit
// Notes: waits keep margin for the free-running divide phase
`timescale 1ns/1ns
module tb_top
    import art_pkg::*;
;
    logic mclk_in = 1'b0, sys_rst_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0;
    logic ext_osc_in = 1'b0, global_irq_en_in = 1'b1, timer_irq_out, event_irq_out;
    logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, rdata_out;
    int err_count = 0, compares = 0;
    // row: write flag, address, data, expected read
    logic [27:0] rows [13] = '{28'h0910000, 28'h0960000, 28'h0980000, 28'h0970000,
        28'h192a500, 28'h09200a5, 28'h1935a00, 28'h093005a, 28'h191ff00, 28'h09100ed,
        28'h1910000, 28'h0910000, 28'h0000000};
    always #10 mclk_in = ~mclk_in;
    // oscillator at half the system rate, within the allowed limit
    always @(posedge mclk_in) ext_osc_in <= ~ext_osc_in;
    art_timer DUT (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .ext_osc_in(ext_osc_in),
        .global_irq_en_in(global_irq_en_in), .rdata_out(rdata_out),
        .timer_irq_out(timer_irq_out), .event_irq_out(event_irq_out));
    task automatic cyc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        wr_in <= w;
        rd_in <= r;
        addr_in <= a;
        wdata_in <= d;
    endtask : cyc
    task automatic idle(input int n);
        repeat (n) cyc(1'b0, 1'b0, 8'h00, 8'h00);
    endtask : idle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cyc(1'b1, 1'b0, a, d);
    endtask : wr
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic rdchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        cyc(1'b0, 1'b1, a, 8'h00);
        idle(1);
        @(negedge mclk_in);
        chk(rdata_out & m, e);
    endtask : rdchk
    task automatic irq(input logic e);
        idle(1);
        @(negedge mclk_in);
        chk({7'h00, timer_irq_out}, {7'h00, e});
    endtask : irq
    // clock control, reload low, reload high, count low, count high, control
    task automatic cfg(input logic [47:0] v);
        wr(ART_CLKCTL_ADDR, v[47:40]);
        wr(ART_RLD_LO_ADDR, v[39:32]);
        wr(ART_RLD_HI_ADDR, v[31:24]);
        wr(ART_CNT_LO_ADDR, v[23:16]);
        wr(ART_CNT_HI_ADDR, v[15:8]);
        wr(ART_CTRL_ADDR, v[7:0]);
    endtask : cfg
    task automatic report_and_stop();
        $display("compares %0d, err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop
    initial
    begin
        idle(12);
        sys_rst_in <= 1'b0;
        foreach (rows[i])
            if (rows[i][24])
                wr(rows[i][23:16], rows[i][15:8]);
            else
                rdchk(rows[i][23:16], 8'hff, rows[i][7:0]);
        $display("register rows done");
        // low byte rolls after 16 ticks, the full count after 272
        cfg(48'h0300fff0fe24);
        idle(30);
        rdchk(ART_CTRL_ADDR, 8'hc0, 8'h40);
        irq(1'b1);
        wr(ART_CTRL_ADDR, 8'h44);
        irq(1'b0);
        idle(260);
        rdchk(ART_CTRL_ADDR, 8'hc0, 8'hc0);
        rdchk(ART_CNT_HI_ADDR, 8'hff, 8'hff);
        irq(1'b1);
        @(posedge mclk_in);
        global_irq_en_in <= 1'b0;
        irq(1'b0);
        @(posedge mclk_in);
        global_irq_en_in <= 1'b1;
        wr(ART_CTRL_ADDR, 8'h00);
        irq(1'b0);
        chk({7'h00, event_irq_out}, 8'h00);
        wr(ART_IRQ_MASK_ADDR, 8'h02);
        irq(1'b0);
        chk({7'h00, event_irq_out}, 8'h01);
        rdchk(ART_IRQ_STAT_ADDR, 8'h02, 8'h02);
        chk({7'h00, event_irq_out}, 8'h00);
        $display("wide mode test done");
        // high byte every cycle, low byte on the divide by 12
        // reloads at f0: a reloaded byte keeps its top nibble set, a wrapped one not
        cfg(48'h02f0f000000c);
        idle(2900);
        rdchk(ART_CTRL_ADDR, 8'hc0, 8'h80);
        rdchk(ART_CNT_HI_ADDR, 8'hf0, 8'hf0);
        irq(1'b1);
        idle(300);
        rdchk(ART_CTRL_ADDR, 8'hc0, 8'hc0);
        rdchk(ART_CNT_LO_ADDR, 8'hf0, 8'hf0);
        wr(ART_CTRL_ADDR, 8'h08);
        wr(ART_CNT_HI_ADDR, 8'h12);
        idle(20);
        rdchk(ART_CNT_HI_ADDR, 8'hff, 8'h12);
        irq(1'b0);
        $display("split mode test done");
        cfg(48'h000000001229);
        idle(3900);
        rdchk(ART_CTRL_ADDR, 8'hc0, 8'h00);
        idle(400);
        rdchk(ART_CTRL_ADDR, 8'hc0, 8'h40);
        irq(1'b1);
        rdchk(ART_CNT_HI_ADDR, 8'hff, 8'h12);
        $display("external clock test done");
        // mid-run reset must drop flags, counts and the request
        idle(1);
        sys_rst_in <= 1'b1;
        idle(2);
        sys_rst_in <= 1'b0;
        irq(1'b0);
        rdchk(ART_CTRL_ADDR, 8'hff, ART_CTRL_RST);
        rdchk(ART_CNT_HI_ADDR, 8'hff, ART_BYTE_RST);
        chk({7'h00, event_irq_out}, 8'h00);
        $display("reset test done");
        report_and_stop();
    end
    initial
    begin
        #400000;
        err_count++;
        report_and_stop();
    end
endmodule : tb_top
